// ===== rtl/tcs_top.sv
/*
  Trace macrocell configuration access through the test access port:
  TAP controller, chain select, 40-bit access chain on TCK, and the
  register store with its access strobes on REF_CLK.
  Assumes a debugger driving TCK/TMS/TDI/TRST_N and a trace macrocell
  that watches the CFG_* strobes.
*/
//
// Summary of operation
// (RL1) registers reached only through scan chain 6
// (RL2) chain is data, address, read/write flag
// (RL3) debugger writes: data, address, flag one
// (RL4) debugger reads: address, flag zero
// (RL5) read ignores data, changes no register
// (RL6) access happens on leaving Update-DR only
// (RL7) read result captured at next Capture-DR
`timescale 1ns/1ps

module tcs_top
  import tcs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  output logic CFG_WR,
  output logic CFG_RD,
  output logic [`TCS_ADDR_W-1:0] CFG_ADDR,
  output logic [`TCS_DATA_W-1:0] CFG_DATA
);

  // link clock domain
  logic trst;
  tcs_tap_e tap;
  tcs_tap_e next_tap;
  logic [`TCS_IR_W-1:0] ir;
  logic [`TCS_IR_W-1:0] ir_shift;
  logic [`TCS_CHAIN_W-1:0] chain;
  logic [`TCS_CHAIN_W-1:0] chain_shift;
  tcs_word_s dr_shift;
  logic byp;
  tcs_word_s held;
  logic req_tgl;
  logic ack_tck;
  logic pending;
  logic sel_trace;
  logic sel_chain;
  logic next_tdo;
  logic req_ref;
  logic req_seen;
  logic do_op;
  logic [`TCS_DATA_W-1:0] regs [`TCS_NUM_REGS];

  assign trst = ~TRST_N;
  assign pending = req_tgl != ack_tck;
  // (RL1) only chain 6 reaches registers
  assign sel_trace = (ir == `TCS_IR_INTEST) && (chain == `TCS_CHAIN_TRACE);
  assign sel_chain = ir == `TCS_IR_SCAN_SEL;

  always_comb begin
    next_tap = tap;
    case (tap)
      TCS_RESET: next_tap = TMS ? TCS_RESET : TCS_IDLE;
      TCS_IDLE: next_tap = TMS ? TCS_DR_SEL : TCS_IDLE;
      TCS_DR_SEL: next_tap = TMS ? TCS_IR_SEL : TCS_DR_CAP;
      TCS_DR_CAP: next_tap = TMS ? TCS_DR_EXIT1 : TCS_DR_SHIFT;
      TCS_DR_SHIFT: next_tap = TMS ? TCS_DR_EXIT1 : TCS_DR_SHIFT;
      TCS_DR_EXIT1: next_tap = TMS ? TCS_DR_UPD : TCS_DR_PAUSE;
      TCS_DR_PAUSE: next_tap = TMS ? TCS_DR_EXIT2 : TCS_DR_PAUSE;
      TCS_DR_EXIT2: next_tap = TMS ? TCS_DR_UPD : TCS_DR_SHIFT;
      TCS_DR_UPD: next_tap = TMS ? TCS_DR_SEL : TCS_IDLE;
      TCS_IR_SEL: next_tap = TMS ? TCS_RESET : TCS_IR_CAP;
      TCS_IR_CAP: next_tap = TMS ? TCS_IR_EXIT1 : TCS_IR_SHIFT;
      TCS_IR_SHIFT: next_tap = TMS ? TCS_IR_EXIT1 : TCS_IR_SHIFT;
      TCS_IR_EXIT1: next_tap = TMS ? TCS_IR_UPD : TCS_IR_PAUSE;
      TCS_IR_PAUSE: next_tap = TMS ? TCS_IR_EXIT2 : TCS_IR_PAUSE;
      TCS_IR_EXIT2: next_tap = TMS ? TCS_IR_UPD : TCS_IR_SHIFT;
      TCS_IR_UPD: next_tap = TMS ? TCS_DR_SEL : TCS_IDLE;
      default: next_tap = TCS_RESET;
    endcase
  end

  always_ff @(posedge TCK or posedge trst) begin
    if (trst) begin
      tap <= TCS_RESET;
    end else begin
      tap <= next_tap;
    end
  end

  // instruction register
  always_ff @(posedge TCK or posedge trst) begin
    if (trst) begin
      ir_shift <= `TCS_IR_CAPTURE;
      ir <= `TCS_IR_RESET;
    end else begin
      case (tap)
        TCS_RESET: ir <= `TCS_IR_RESET;
        TCS_IR_CAP: ir_shift <= `TCS_IR_CAPTURE;
        TCS_IR_SHIFT: ir_shift <= {TDI, ir_shift[`TCS_IR_W-1:1]};
        TCS_IR_UPD: ir <= ir_shift;
        default: ir <= ir;
      endcase
    end
  end

  // (RL1) chain number register
  always_ff @(posedge TCK or posedge trst) begin
    if (trst) begin
      chain_shift <= `TCS_CHAIN_RESET;
      chain <= `TCS_CHAIN_RESET;
    end else if (tap == TCS_RESET) begin
      chain <= `TCS_CHAIN_RESET;
    end else if (sel_chain) begin
      if (tap == TCS_DR_CAP) begin
        chain_shift <= chain;
      end else if (tap == TCS_DR_SHIFT) begin
        chain_shift <= {TDI, chain_shift[`TCS_CHAIN_W-1:1]};
      end else if (tap == TCS_DR_UPD) begin
        chain <= chain_shift;
      end
    end
  end

  // (RL2) 40-bit access chain
  always_ff @(posedge TCK or posedge trst) begin
    if (trst) begin
      dr_shift <= '0;
      byp <= 1'b0;
    end else begin
      if (tap == TCS_DR_CAP) begin
        byp <= 1'b0;
      end else if (tap == TCS_DR_SHIFT) begin
        byp <= TDI;
      end
      if (sel_trace && tap == TCS_DR_CAP) begin
        // (RL7) last CFG_DATA into data: read result, or written word after a write
        dr_shift.data <= CFG_DATA;
        dr_shift.addr <= held.addr;
        dr_shift.wr <= held.wr;
      end else if (sel_trace && tap == TCS_DR_SHIFT) begin
        dr_shift <= {TDI, dr_shift[`TCS_CHAIN_LEN-1:1]};
      end
    end
  end

  // (RL6) request launched on Update-DR
  always_ff @(posedge TCK or posedge trst) begin
    if (trst) begin
      held <= '0;
      req_tgl <= 1'b0;
    end else if (sel_trace && tap == TCS_DR_UPD && !pending) begin
      held <= dr_shift;
      req_tgl <= ~req_tgl;
    end
  end

  always_comb begin
    next_tdo = byp;
    if (tap == TCS_IR_SHIFT) begin
      next_tdo = ir_shift[0];
    end else if (sel_trace) begin
      next_tdo = dr_shift[0];
    end else if (sel_chain) begin
      next_tdo = chain_shift[0];
    end
  end

  // output changes on the falling edge
  always_ff @(negedge TCK or posedge trst) begin
    if (trst) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO <= next_tdo;
      TDO_OE <= (tap == TCS_DR_SHIFT) || (tap == TCS_IR_SHIFT);
    end
  end

  tcs_sync u_ack_sync (
    .clk(TCK),
    .rst(trst),
    .d(req_seen),
    .q(ack_tck)
  );

  // core clock domain
  tcs_sync u_req_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(req_tgl),
    .q(req_ref)
  );

  assign do_op = req_ref != req_seen;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      req_seen <= 1'b0;
    end else begin
      req_seen <= req_ref;
    end
  end

  // register store, one entry per address
  genvar gi;
  generate
    for (gi = 0; gi < `TCS_NUM_REGS; gi = gi + 1) begin : g_reg
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          regs[gi] <= `TCS_REG_RESET;
        // (RL3) (RL5) only flag one writes
        end else if (do_op && held.wr && held.addr == `TCS_ADDR_W'(gi)) begin
          regs[gi] <= held.data;
        end
      end
    end
  endgenerate

  // access strobes towards the macrocell
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CFG_WR <= 1'b0;
      CFG_RD <= 1'b0;
      CFG_ADDR <= '0;
      CFG_DATA <= `TCS_REG_RESET;
    end else begin
      CFG_WR <= do_op && held.wr;
      // (RL4) flag zero reads
      CFG_RD <= do_op && !held.wr;
      if (do_op) begin
        CFG_ADDR <= held.addr;
        // (RL5) read takes stored value
        CFG_DATA <= held.wr ? held.data : regs[held.addr];
      end
    end
  end

endmodule

// ===== rtl/tcs_regs.svh
/*
  Constants of the trace macrocell scan access path: instruction codes,
  chain number, field widths and reset values.
  Assumes inclusion by bare name from the package and the bench modules.
*/
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

`define TCS_IR_W 4
`define TCS_IR_SCAN_SEL 4'h2
`define TCS_IR_INTEST 4'hc
`define TCS_IR_BYPASS 4'hf
`define TCS_IR_CAPTURE 4'h1
`define TCS_IR_RESET 4'hf
`define TCS_CHAIN_W 4
`define TCS_CHAIN_TRACE 4'h6
`define TCS_CHAIN_RESET 4'h0
`define TCS_CHAIN_LEN 40
`define TCS_DATA_W 32
`define TCS_ADDR_W 7
`define TCS_NUM_REGS 128
`define TCS_REG_RESET 32'h0000_0000

`endif

// ===== rtl/tcs_pkg.sv
/*
  Types of the trace macrocell scan access path.
  Assumes tcs_regs.svh on the include path.
*/
`include "tcs_regs.svh"

package tcs_pkg;

  // chain word, shifted in from bit 0: data, then address, then flag
  typedef struct packed {
    logic wr;
    logic [`TCS_ADDR_W-1:0] addr;
    logic [`TCS_DATA_W-1:0] data;
  } tcs_word_s;

  typedef enum logic [3:0] {
    TCS_RESET, TCS_IDLE,
    TCS_DR_SEL, TCS_DR_CAP, TCS_DR_SHIFT, TCS_DR_EXIT1,
    TCS_DR_PAUSE, TCS_DR_EXIT2, TCS_DR_UPD,
    TCS_IR_SEL, TCS_IR_CAP, TCS_IR_SHIFT, TCS_IR_EXIT1,
    TCS_IR_PAUSE, TCS_IR_EXIT2, TCS_IR_UPD
  } tcs_tap_e;

endpackage

// ===== rtl/tcs_sync.sv
/*
  Two-stage level synchroniser for one bit.
  Assumes an asynchronous active-high reset of the destination domain.
*/
`timescale 1ns/1ps

module tcs_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ===== bench/tcs_top_properties.sv
/* Checker on the ports of tcs_top: strobe shape, field hold, TDO enable.
   Assumes it is bound to tcs_top. */
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_top_properties
  import tcs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [`TCS_ADDR_W-1:0] CFG_ADDR,
  input wire logic [`TCS_DATA_W-1:0] CFG_DATA
);
  sequence s_acc;
    CFG_WR || CFG_RD;
  endsequence
  sequence s_quiet;
    !CFG_WR && !CFG_RD;
  endsequence
  a_one_strobe: assert property (
    @(posedge REF_CLK) disable iff (RST) s_acc |=> s_quiet)
    else $error("access strobe longer than one cycle");
  a_strobe_excl: assert property (
    @(posedge REF_CLK) disable iff (RST) !(CFG_WR && CFG_RD))
    else $error("read and write strobes together");
  a_fields_hold: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_quiet |-> $stable(CFG_ADDR) && $stable(CFG_DATA))
    else $error("access fields changed without a strobe");
  a_oe_off: assert property (
    @(posedge TCK) disable iff (!TRST_N) TMS |=> !TDO_OE)
    else $error("tdo driven outside shift");
  a_oe_tap_reset: assert property (
    @(posedge TCK) disable iff (!TRST_N) TMS [*5] |-> !TDO_OE)
    else $error("tdo driven after tap reset");
endmodule

// ===== bench/tcs_dbg.sv
/* Debugger model: drives the TAP, TCK runs only inside scans and TAP resets.
   Assumes the TAP contract of tcs_top. */
`timescale 1ns/1ps
module tcs_dbg (
  output logic TCK,
  output logic TRST_N,
  output logic TMS,
  output logic TDI,
  input wire logic TDO
);
  logic x;
  initial begin
    TCK = 1'b0;
    TRST_N = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  task automatic tick(input logic m, input logic d, output logic q);
    TMS = m;
    TDI = d;
    #40 TCK = 1'b1;
    q = TDO;
    #40 TCK = 1'b0;
  endtask
  task automatic reset_tap();
    tick(1'b1, ~TDI, x);
    TRST_N = 1'b1;
    repeat (5) tick(1'b1, ~TDI, x);
    tick(1'b0, ~TDI, x);
  endtask
  task automatic scan(input logic ir, input int n, input logic [39:0] d,
                      output logic [39:0] q);
    #7 tick(1'b1, ~TDI, x);
    if (ir) tick(1'b1, ~TDI, x);
    tick(1'b0, ~TDI, x);
    tick(1'b0, ~TDI, x);
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
    tick(1'b1, ~TDI, x);
    repeat (3) tick(1'b0, ~TDI, x);
  endtask
endmodule

// ===== bench/tb_tcs_top.sv
/* Testbench of tcs_top: writes, reads and refused accesses via the TAP.
   Assumes tcs_dbg as debugger and the bound checker. */
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tb_tcs_top
  import tcs_pkg::*;
;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic TCK, TRST_N, TMS, TDI, TDO, TDO_OE, CFG_WR, CFG_RD;
  logic [`TCS_ADDR_W-1:0] CFG_ADDR;
  logic [`TCS_DATA_W-1:0] CFG_DATA;
  tcs_word_s q;
  int fail_count = 0;
  int total_checks = 0;
  int nwr = 0;
  int nrd = 0;
  int noe = 0;
  always #10 REF_CLK = ~REF_CLK;
  // strobes launched on the rising edge, counted on the falling one
  always @(negedge REF_CLK) begin
    if (CFG_WR === 1'b1) nwr++;
    if (CFG_RD === 1'b1) nrd++;
  end
  // shift cycles with tdo driven, one per bit shifted
  always @(posedge TCK) begin
    if (TDO_OE === 1'b1) noe++;
  end
  tcs_top dut (.REF_CLK, .RST, .TCK, .TRST_N, .TMS, .TDI, .TDO, .TDO_OE,
    .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_DATA);
  tcs_dbg dbg (.TCK, .TRST_N, .TMS, .TDI, .TDO);
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    dbg.scan(1'b0, 40, {w, a, d}, q);
    repeat (12) @(negedge REF_CLK);
  endtask
  task automatic t_write();
    dbg.scan(1'b1, 4, 40'h2, q);
    dbg.scan(1'b0, 4, 40'h6, q);
    dbg.scan(1'b1, 4, 40'hc, q);
    acc(1'b1, 7'h7f, 32'ha5a5_3c3c);
    chk(nwr, 1);
    chk(CFG_ADDR, 7'h7f);
    chk(CFG_DATA, 32'ha5a5_3c3c);
    acc(1'b1, 7'h00, 32'h5a00_00c3);
    chk(nwr, 2);
    chk(noe, 92);
  endtask
  task automatic t_read();
    acc(1'b0, 7'h7f, 32'hffff_ffff);
    chk(nrd, 1);
    chk(nwr, 2);
    chk(CFG_DATA, 32'ha5a5_3c3c);
    acc(1'b0, 7'h00, 32'h0);
    chk(q.data, 32'ha5a5_3c3c);
    chk({q.wr, q.addr}, 8'h7f);
    chk(CFG_DATA, 32'h5a00_00c3);
    acc(1'b0, 7'h7f, 32'h0);
    chk(q.data, 32'h5a00_00c3);
    chk(CFG_DATA, 32'ha5a5_3c3c);
  endtask
  task automatic t_other();
    dbg.reset_tap();
    acc(1'b1, 7'h01, 32'hffff_ffff);
    dbg.scan(1'b1, 4, 40'hc, q);
    acc(1'b1, 7'h01, 32'hffff_ffff);
    chk(nwr, 2);
    chk(nrd, 3);
  endtask
  initial begin
    repeat (10) @(negedge REF_CLK);
    RST = 1'b0;
    dbg.reset_tap();
    t_write();
    t_read();
    t_other();
    give_verdict();
  end
  initial begin
    #300us;
    fail_count++;
    $display("unexpected at %0t: timeout", $time);
    give_verdict();
  end
endmodule
bind tcs_top tcs_top_properties chk_i (.REF_CLK, .RST, .TCK, .TRST_N,
  .TMS, .TDI, .TDO, .TDO_OE, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_DATA);
